/* File: rtl/metering_irq_pkg.sv */
// constants shared by the metering interrupt flag block
package metering_irq_pkg;

  // register byte offsets on the special function register port
  localparam logic [7:0] OFS_IRQ_ENABLE_LOW = 8'hd9;
  localparam logic [7:0] OFS_IRQ_ENABLE_MID = 8'hda;
  localparam logic [7:0] OFS_IRQ_ENABLE_HIGH = 8'hdb;
  localparam logic [7:0] OFS_IRQ_STATUS_LOW = 8'hdc;
  localparam logic [7:0] OFS_IRQ_STATUS_MID = 8'hdd;
  localparam logic [7:0] OFS_IRQ_STATUS_HIGH = 8'hde;

  // implemented bits per register; the rest read zero, except low status bit 7, which reads the summary
  localparam logic [7:0] MASK_LOW = 8'h3f;
  localparam logic [7:0] MASK_MID = 8'hff;
  localparam logic [7:0] MASK_HIGH = 8'hbf;
  // high enable has no bit 7, so reset done alone never raises the summary
  localparam logic [7:0] MASK_ENABLE_HIGH = 8'h3f;

  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // low status / enable fields
  localparam int BIT_SUMMARY = 7;
  localparam int BIT_FAULT_MODE_CHANGE = 5;
  localparam int BIT_REACTIVE_SIGN_CHANGE = 4;
  localparam int BIT_ACTIVE_SIGN_CHANGE = 3;
  localparam int BIT_APPARENT_NOLOAD = 2;
  localparam int BIT_REACTIVE_NOLOAD = 1;
  localparam int BIT_ACTIVE_NOLOAD = 0;

  // mid status / enable fields
  localparam int BIT_PULSE_OUT_SECOND = 7;
  localparam int BIT_PULSE_OUT_FIRST = 6;
  localparam int BIT_APPARENT_OVERFLOW = 5;
  localparam int BIT_REACTIVE_OVERFLOW = 4;
  localparam int BIT_ACTIVE_OVERFLOW = 3;
  localparam int BIT_APPARENT_HALF = 2;
  localparam int BIT_REACTIVE_HALF = 1;
  localparam int BIT_ACTIVE_HALF = 0;

  // high status / enable fields
  localparam int BIT_RESET_DONE = 7;
  localparam int BIT_WAVEFORM_READY = 5;
  localparam int BIT_CURRENT_PEAK = 4;
  localparam int BIT_VOLTAGE_PEAK = 3;
  localparam int BIT_LINE_CYCLE_DONE = 2;
  localparam int BIT_CROSSING_TIMEOUT = 1;
  localparam int BIT_VOLTAGE_CROSSING = 0;

  // index of each register in the flag and enable arrays
  localparam int IDX_LOW = 0;
  localparam int IDX_MID = 1;
  localparam int IDX_HIGH = 2;
  localparam int NUM_REGS = 3;

endpackage : metering_irq_pkg

/* File: rtl/metering_interrupt_flags.sv */
// interrupt status and enable registers of the metering front end
//
// Operation
// - summary bit set while any enabled flag set
// - low bit 5 on fault mode change
// - low bit 4 on reactive sign change
// - low bit 3 on active sign change
// - low bit 2 on apparent or rms noload
// - low bits 1,0 on reactive/active noload
// - mid bit 7 on every second pulse
// - mid bit 6 on every first pulse
// - mid bits 5..3 on accumulator overflow
// - mid bits 2..0 on accumulator half full
// - high bit 7 at end of any reset
// - high bit 5 on new waveform samples
// - high bit 4 when current exceeds threshold
// - high bit 3 when voltage exceeds threshold
// - high bit 2 at line cycle accumulation end
// - high bit 1 on zero crossing timeout
// - high bit 0 on voltage zero crossing
// - low enable bits 5..0 gate low flags
// - mid enable bits 7..0 gate mid flags
// - high enable bits 5..0 gate high flags
// - sign detect on filtered power or per pulse
`timescale 1ns/1ps

module metering_interrupt_flags #(
  parameter int CURRENT_WIDTH = 24,
  parameter int VOLTAGE_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // software reset request, held high while the reset lasts
  input wire logic soft_reset,
  // sign and mode levels from the power datapath
  input wire logic sign_detect_select,
  input wire logic active_power_sign,
  input wire logic reactive_power_sign,
  input wire logic fault_mode,
  // one-cycle event pulses from the datapath
  input wire logic pulse_out_first,
  input wire logic pulse_out_second,
  input wire logic apparent_noload,
  input wire logic irms_noload_enter,
  input wire logic reactive_noload,
  input wire logic active_noload,
  input wire logic apparent_energy_overflow,
  input wire logic reactive_energy_overflow,
  input wire logic active_energy_overflow,
  input wire logic apparent_energy_half,
  input wire logic reactive_energy_half,
  input wire logic active_energy_half,
  input wire logic waveform_sample_ready,
  input wire logic line_cycle_done,
  input wire logic crossing_timeout,
  input wire logic voltage_crossing,
  // waveform samples and peak thresholds
  input wire logic [CURRENT_WIDTH-1:0] current_sample,
  input wire logic [VOLTAGE_WIDTH-1:0] voltage_sample,
  input wire logic [CURRENT_WIDTH-1:0] current_peak_threshold,
  input wire logic [VOLTAGE_WIDTH-1:0] voltage_peak_threshold,
  // pending interrupt toward the processor core
  output logic metering_irq_summary
);

  logic [7:0] flags_q [metering_irq_pkg::NUM_REGS];
  logic [7:0] enable_q [metering_irq_pkg::NUM_REGS];
  logic [7:0] set_vec [metering_irq_pkg::NUM_REGS];
  logic [7:0] clr_vec [metering_irq_pkg::NUM_REGS];
  logic [7:0] reg_mask [metering_irq_pkg::NUM_REGS];

  logic summary_q;
  logic [7:0] rdata_q;

  // sign tracking
  logic sign_valid_q;
  logic act_prev_q;
  logic react_prev_q;
  logic fault_prev_q;
  logic act_pulse_q;
  logic react_pulse_q;
  logic act_pulse_valid_q;
  logic react_pulse_valid_q;
  logic act_change;
  logic react_change;
  logic fault_change;

  // reset end tracking
  logic boot_done_q;
  logic soft_prev_q;
  logic reset_end;

  // peak detection
  logic [CURRENT_WIDTH-1:0] current_mag;
  logic [VOLTAGE_WIDTH-1:0] voltage_mag;
  logic current_peak;
  logic voltage_peak;

  assign reg_mask[metering_irq_pkg::IDX_LOW] = metering_irq_pkg::MASK_LOW;
  assign reg_mask[metering_irq_pkg::IDX_MID] = metering_irq_pkg::MASK_MID;
  assign reg_mask[metering_irq_pkg::IDX_HIGH] = metering_irq_pkg::MASK_HIGH;

  // sign change detection

  // filtered-signal history; the valid bit stops the first sample after
  // reset from looking like a change
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sign_valid_q <= 1'b0;
      act_prev_q <= 1'b0;
      react_prev_q <= 1'b0;
      fault_prev_q <= 1'b0;
    end else begin
      sign_valid_q <= 1'b1;
      act_prev_q <= active_power_sign;
      react_prev_q <= reactive_power_sign;
      fault_prev_q <= fault_mode;
    end
  end

  // per-pulse history: the sign is only looked at when a pulse leaves
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      act_pulse_q <= 1'b0;
      react_pulse_q <= 1'b0;
      act_pulse_valid_q <= 1'b0;
      react_pulse_valid_q <= 1'b0;
    end else begin
      if (pulse_out_first) begin
        act_pulse_q <= active_power_sign;
        act_pulse_valid_q <= 1'b1;
      end
      if (pulse_out_second) begin
        react_pulse_q <= reactive_power_sign;
        react_pulse_valid_q <= 1'b1;
      end
    end
  end

  always_comb begin
    if (sign_detect_select) begin
      act_change = pulse_out_first && act_pulse_valid_q
                   && (active_power_sign != act_pulse_q);
      react_change = pulse_out_second && react_pulse_valid_q
                     && (reactive_power_sign != react_pulse_q);
    end else begin
      act_change = sign_valid_q && (active_power_sign != act_prev_q);
      react_change = sign_valid_q && (reactive_power_sign != react_prev_q);
    end
  end

  assign fault_change = sign_valid_q && (fault_mode != fault_prev_q);

  // reset end

  // hardware reset end shows one edge after release; software reset end
  // shows on the falling edge of its request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      boot_done_q <= 1'b0;
      soft_prev_q <= 1'b0;
    end else begin
      boot_done_q <= 1'b1;
      soft_prev_q <= soft_reset;
    end
  end

  assign reset_end = !boot_done_q || (soft_prev_q && !soft_reset);

  // peak detection

  // magnitude of the twos complement sample; the most negative code
  // wraps back to its own pattern, which still compares as largest
  always_comb begin
    if (current_sample[CURRENT_WIDTH-1]) begin
      current_mag = CURRENT_WIDTH'(~current_sample + 1'b1);
    end else begin
      current_mag = current_sample;
    end
    if (voltage_sample[VOLTAGE_WIDTH-1]) begin
      voltage_mag = VOLTAGE_WIDTH'(~voltage_sample + 1'b1);
    end else begin
      voltage_mag = voltage_sample;
    end
  end

  // compared only when a fresh sample lands
  assign current_peak = waveform_sample_ready
                        && (current_mag > current_peak_threshold);
  assign voltage_peak = waveform_sample_ready
                        && (voltage_mag > voltage_peak_threshold);

  // event to flag mapping

  always_comb begin
    set_vec[metering_irq_pkg::IDX_LOW] = 8'h00;
    set_vec[metering_irq_pkg::IDX_LOW][metering_irq_pkg::BIT_FAULT_MODE_CHANGE] =
      fault_change;
    set_vec[metering_irq_pkg::IDX_LOW][metering_irq_pkg::BIT_REACTIVE_SIGN_CHANGE] =
      react_change;
    set_vec[metering_irq_pkg::IDX_LOW][metering_irq_pkg::BIT_ACTIVE_SIGN_CHANGE] =
      act_change;
    set_vec[metering_irq_pkg::IDX_LOW][metering_irq_pkg::BIT_APPARENT_NOLOAD] =
      apparent_noload || irms_noload_enter;
    set_vec[metering_irq_pkg::IDX_LOW][metering_irq_pkg::BIT_REACTIVE_NOLOAD] =
      reactive_noload;
    set_vec[metering_irq_pkg::IDX_LOW][metering_irq_pkg::BIT_ACTIVE_NOLOAD] =
      active_noload;

    // pulse flags follow the pulse even while the pin itself is disabled
    set_vec[metering_irq_pkg::IDX_MID] = 8'h00;
    set_vec[metering_irq_pkg::IDX_MID][metering_irq_pkg::BIT_PULSE_OUT_SECOND] =
      pulse_out_second;
    set_vec[metering_irq_pkg::IDX_MID][metering_irq_pkg::BIT_PULSE_OUT_FIRST] =
      pulse_out_first;
    set_vec[metering_irq_pkg::IDX_MID][metering_irq_pkg::BIT_APPARENT_OVERFLOW] =
      apparent_energy_overflow;
    set_vec[metering_irq_pkg::IDX_MID][metering_irq_pkg::BIT_REACTIVE_OVERFLOW] =
      reactive_energy_overflow;
    set_vec[metering_irq_pkg::IDX_MID][metering_irq_pkg::BIT_ACTIVE_OVERFLOW] =
      active_energy_overflow;
    set_vec[metering_irq_pkg::IDX_MID][metering_irq_pkg::BIT_APPARENT_HALF] =
      apparent_energy_half;
    set_vec[metering_irq_pkg::IDX_MID][metering_irq_pkg::BIT_REACTIVE_HALF] =
      reactive_energy_half;
    set_vec[metering_irq_pkg::IDX_MID][metering_irq_pkg::BIT_ACTIVE_HALF] =
      active_energy_half;

    set_vec[metering_irq_pkg::IDX_HIGH] = 8'h00;
    set_vec[metering_irq_pkg::IDX_HIGH][metering_irq_pkg::BIT_RESET_DONE] =
      reset_end;
    set_vec[metering_irq_pkg::IDX_HIGH][metering_irq_pkg::BIT_WAVEFORM_READY] =
      waveform_sample_ready;
    set_vec[metering_irq_pkg::IDX_HIGH][metering_irq_pkg::BIT_CURRENT_PEAK] =
      current_peak;
    set_vec[metering_irq_pkg::IDX_HIGH][metering_irq_pkg::BIT_VOLTAGE_PEAK] =
      voltage_peak;
    set_vec[metering_irq_pkg::IDX_HIGH][metering_irq_pkg::BIT_LINE_CYCLE_DONE] =
      line_cycle_done;
    set_vec[metering_irq_pkg::IDX_HIGH][metering_irq_pkg::BIT_CROSSING_TIMEOUT] =
      crossing_timeout;
    set_vec[metering_irq_pkg::IDX_HIGH][metering_irq_pkg::BIT_VOLTAGE_CROSSING] =
      voltage_crossing;
  end

  // software clear

  // writing 0 to a flag clears it, writing 1 leaves it; this way writing
  // ones to all other bits clears one bit without wiping flags raised in between
  always_comb begin
    for (int r = 0; r < metering_irq_pkg::NUM_REGS; r++) begin
      clr_vec[r] = 8'h00;
    end
    if (sfr_wr) begin
      if (sfr_addr == metering_irq_pkg::OFS_IRQ_STATUS_LOW) begin
        clr_vec[metering_irq_pkg::IDX_LOW] = ~sfr_wdata;
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_STATUS_MID) begin
        clr_vec[metering_irq_pkg::IDX_MID] = ~sfr_wdata;
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_STATUS_HIGH) begin
        clr_vec[metering_irq_pkg::IDX_HIGH] = ~sfr_wdata;
      end
    end
  end

  // sticky flags, one per bit

  for (genvar g = 0; g < metering_irq_pkg::NUM_REGS * 8; g++) begin : g_flag
    localparam int R = g / 8;
    localparam int B = g % 8;
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        flags_q[R][B] <= metering_irq_pkg::RESET_STATUS[B];
      end else if (!reg_mask[R][B]) begin
        flags_q[R][B] <= 1'b0;
      end else if (set_vec[R][B]) begin
        flags_q[R][B] <= 1'b1;
      end else if (clr_vec[R][B]) begin
        flags_q[R][B] <= 1'b0;
      end
    end
  end

  // enable registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int r = 0; r < metering_irq_pkg::NUM_REGS; r++) begin
        enable_q[r] <= metering_irq_pkg::RESET_ENABLE;
      end
    end else if (sfr_wr) begin
      if (sfr_addr == metering_irq_pkg::OFS_IRQ_ENABLE_LOW) begin
        enable_q[metering_irq_pkg::IDX_LOW] <= sfr_wdata
                                               & metering_irq_pkg::MASK_LOW;
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_ENABLE_MID) begin
        enable_q[metering_irq_pkg::IDX_MID] <= sfr_wdata
                                               & metering_irq_pkg::MASK_MID;
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_ENABLE_HIGH) begin
        enable_q[metering_irq_pkg::IDX_HIGH] <= sfr_wdata
                                                & metering_irq_pkg::MASK_ENABLE_HIGH;
      end
    end
  end

  // summary flag

  // registered so the core sees a clean level; it lags the flags by one edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= |(flags_q[metering_irq_pkg::IDX_LOW]
                     & enable_q[metering_irq_pkg::IDX_LOW])
                   | |(flags_q[metering_irq_pkg::IDX_MID]
                       & enable_q[metering_irq_pkg::IDX_MID])
                   | |(flags_q[metering_irq_pkg::IDX_HIGH]
                       & enable_q[metering_irq_pkg::IDX_HIGH]);
    end
  end

  assign metering_irq_summary = summary_q;

  // read port

  // data appears the edge after the read strobe; reads have no side effect
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= metering_irq_pkg::READ_UNMAPPED;
    end else if (sfr_rd) begin
      if (sfr_addr == metering_irq_pkg::OFS_IRQ_ENABLE_LOW) begin
        rdata_q <= enable_q[metering_irq_pkg::IDX_LOW];
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_ENABLE_MID) begin
        rdata_q <= enable_q[metering_irq_pkg::IDX_MID];
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_ENABLE_HIGH) begin
        rdata_q <= enable_q[metering_irq_pkg::IDX_HIGH];
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_STATUS_LOW) begin
        rdata_q <= {summary_q, flags_q[metering_irq_pkg::IDX_LOW][6:0]};
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_STATUS_MID) begin
        rdata_q <= flags_q[metering_irq_pkg::IDX_MID];
      end else if (sfr_addr == metering_irq_pkg::OFS_IRQ_STATUS_HIGH) begin
        rdata_q <= flags_q[metering_irq_pkg::IDX_HIGH];
      end else begin
        rdata_q <= metering_irq_pkg::READ_UNMAPPED;
      end
    end
  end

  assign sfr_rdata = rdata_q;

endmodule : metering_interrupt_flags

/* File: verif/metering_irq_monitor.sv */
// checker on the ports of the metering interrupt flag block
`timescale 1ns/1ps
module metering_irq_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_rdata,
  input wire logic voltage_crossing,
  input wire logic pulse_out_second,
  input wire logic apparent_energy_overflow,
  input wire logic metering_irq_summary
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic rd_lo;
  logic rd_mid;
  logic rd_hi;
  assign rd_lo = sfr_rd && sfr_addr == 8'hdc;
  assign rd_mid = sfr_rd && sfr_addr == 8'hdd;
  assign rd_hi = sfr_rd && sfr_addr == 8'hde;
  // the idle cycle between event and read must carry no write, or a clear could land
  a_unmapped_zero: assert property (sfr_rd && (sfr_addr < 8'hd9 || sfr_addr > 8'hde)
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_reserved_enable: assert property (sfr_rd && (sfr_addr == 8'hd9 || sfr_addr == 8'hdb)
    |=> sfr_rdata[7:6] == 2'h0) else $error("reserved enable bits set");
  a_reserved_status: assert property (rd_lo || rd_hi |=> !sfr_rdata[6])
    else $error("reserved status bit set");
  a_summary_bit: assert property (rd_lo |=> sfr_rdata[7] == $past(metering_irq_summary))
    else $error("summary bit differs from summary output");
  a_crossing_flag: assert property (voltage_crossing ##1 !sfr_wr ##1 rd_hi |=> sfr_rdata[0])
    else $error("crossing flag missing");
  a_pulse_flag: assert property (pulse_out_second ##1 !sfr_wr ##1 rd_mid |=> sfr_rdata[7])
    else $error("second pulse flag missing");
  a_overflow_flag: assert property (apparent_energy_overflow ##1 !sfr_wr ##1 rd_mid
    |=> sfr_rdata[5]) else $error("overflow flag missing");
  a_reset_done: assert property ($fell(sys_rst) ##1 rd_hi |=> sfr_rdata[7])
    else $error("reset done flag missing");
  a_summary_quiet: assert property ($fell(sys_rst) |-> (!metering_irq_summary) [*2])
    else $error("summary high after reset");
  cover property ($rose(metering_irq_summary));
  cover property ($fell(metering_irq_summary));
  cover property (sfr_rd && sfr_addr == 8'hdf);
endmodule : metering_irq_monitor

bind metering_interrupt_flags metering_irq_monitor u_mon (.core_clk, .sys_rst, .sfr_addr,
  .sfr_rd, .sfr_wr, .sfr_rdata, .voltage_crossing, .pulse_out_second,
  .apparent_energy_overflow, .metering_irq_summary);

/* File: verif/sfr_host_model.sv */
// processor core model issuing register cycles
`timescale 1ns/1ps
module sfr_host_model (
  input wire logic core_clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  output logic sfr_rd,
  input wire logic [7:0] sfr_rdata
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
  end
  // idle bus shows inverted values, so a stale address never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    d = sfr_rdata;
  endtask : rd
endmodule : sfr_host_model

/* File: verif/tb_top.sv */
// self-checking bench for the metering interrupt flag block
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_reset = 1'b0;
  logic sign_detect_select = 1'b0;
  logic active_power_sign = 1'b0;
  logic reactive_power_sign = 1'b0;
  logic fault_mode = 1'b0;
  logic [15:0] ev = 16'h0000;
  logic [23:0] current_sample = 24'h000000;
  logic [15:0] voltage_sample = 16'h0000;
  logic [23:0] ipk_thr = 24'h000100;
  logic [15:0] vpk_thr = 16'h0100;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic sfr_wr;
  logic sfr_rd;
  logic metering_irq_summary;
  int n_fail = 0;
  int samples_checked = 0;
  // event line i lands on this status bit: mid for 0..7, low 8..11, high 12..15
  localparam int EV_BIT [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 1, 2, 2, 0, 1, 2, 5};
  localparam logic [7:0] EN_MASK [3] = '{8'h3f, 8'hff, 8'h3f};
  localparam logic [7:0] EN_ONE [3] = '{8'h01, 8'h80, 8'h01};
  localparam logic [15:0] EV_ONE [3] = '{16'h0100, 16'h0080, 16'h1000};
  localparam logic [7:0] LOW_RD [3] = '{8'h81, 8'h80, 8'h80};

  always #5 core_clk = ~core_clk;

  metering_interrupt_flags u_dut (
    .core_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .soft_reset,
    .sign_detect_select, .active_power_sign, .reactive_power_sign, .fault_mode,
    .pulse_out_first(ev[6]), .pulse_out_second(ev[7]), .apparent_noload(ev[10]),
    .irms_noload_enter(ev[11]), .reactive_noload(ev[9]), .active_noload(ev[8]),
    .apparent_energy_overflow(ev[5]), .reactive_energy_overflow(ev[4]),
    .active_energy_overflow(ev[3]), .apparent_energy_half(ev[2]),
    .reactive_energy_half(ev[1]), .active_energy_half(ev[0]),
    .waveform_sample_ready(ev[15]), .line_cycle_done(ev[14]),
    .crossing_timeout(ev[13]), .voltage_crossing(ev[12]), .current_sample, .voltage_sample,
    .current_peak_threshold(ipk_thr), .voltage_peak_threshold(vpk_thr),
    .metering_irq_summary);

  sfr_host_model u_host (.core_clk, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata);

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h expected %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, e, "register read");
  endtask : rchk

  // summary is registered behind the flags, so allow two edges
  task automatic sumchk(input logic e);
    repeat (2) @(negedge core_clk);
    chk({7'h00, metering_irq_summary}, {7'h00, e}, "summary");
  endtask : sumchk

  task automatic pulse(input logic [15:0] m);
    @(negedge core_clk);
    ev = m;
    @(negedge core_clk);
    ev = 16'h0000;
  endtask : pulse

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
  endtask : do_reset

  task automatic s_reset_values();
    rchk(8'hde, 8'h80);
    u_host.wr(8'hde, 8'h00);
    for (int a = 8'hd8; a <= 8'hdf; a++) begin
      rchk(8'(a), 8'h00);
    end
    for (int r = 0; r < 3; r++) begin
      u_host.wr(8'hd9 + 8'(r), 8'hff);
      rchk(8'hd9 + 8'(r), EN_MASK[r]);
      u_host.wr(8'hd9 + 8'(r), 8'h00);
    end
    u_host.wr(8'hdf, 8'hff);
    rchk(8'hdf, 8'h00);
  endtask : s_reset_values

  task automatic s_events();
    logic [7:0] o;
    logic [7:0] e;
    for (int i = 0; i < 16; i++) begin
      o = (i < 8) ? 8'hdd : (i < 12) ? 8'hdc : 8'hde;
      e = 8'h01 << EV_BIT[i];
      pulse(16'h0001 << i);
      if (i < 12) begin
        rchk(o, e);
      end else begin
        rchk(o, e);
      end
      sumchk(1'b0);
      u_host.wr(o, 8'hff);
      rchk(o, e);
      u_host.wr(o, ~e);
      rchk(o, 8'h00);
    end
  endtask : s_events

  task automatic s_sign();
    @(negedge core_clk);
    active_power_sign = 1'b1;
    reactive_power_sign = 1'b1;
    fault_mode = 1'b1;
    rchk(8'hdc, 8'h38);
    sign_detect_select = 1'b1;
    pulse(16'h00c0);
    u_host.wr(8'hdc, 8'h00);
    u_host.wr(8'hdd, 8'h00);
    active_power_sign = 1'b0;
    reactive_power_sign = 1'b0;
    rchk(8'hdc, 8'h00);
    pulse(16'h00c0);
    rchk(8'hdc, 8'h18);
    u_host.wr(8'hdc, 8'h00);
    u_host.wr(8'hdd, 8'h00);
  endtask : s_sign

  task automatic s_summary();
    for (int r = 0; r < 3; r++) begin
      u_host.wr(8'hd9 + 8'(r), EN_ONE[r]);
      pulse(EV_ONE[r]);
      sumchk(1'b1);
      rchk(8'hdc, LOW_RD[r]);
      u_host.wr(8'hdc + 8'(r), 8'h00);
      sumchk(1'b0);
      u_host.wr(8'hd9 + 8'(r), 8'h00);
    end
  endtask : s_summary

  // magnitude equal to the threshold must not count, one above must
  task automatic s_peak();
    current_sample = 24'hffff00;
    voltage_sample = 16'h0100;
    pulse(16'h8000);
    rchk(8'hde, 8'h20);
    u_host.wr(8'hde, 8'h00);
    current_sample = 24'hfffeff;
    voltage_sample = 16'h0101;
    pulse(16'h8000);
    rchk(8'hde, 8'h38);
    u_host.wr(8'hde, 8'h00);
    ipk_thr = 24'h000101;
    vpk_thr = 16'h0101;
    pulse(16'h8000);
    rchk(8'hde, 8'h20);
    u_host.wr(8'hde, 8'h00);
  endtask : s_peak

  task automatic s_soft();
    @(negedge core_clk);
    soft_reset = 1'b1;
    repeat (2) @(negedge core_clk);
    soft_reset = 1'b0;
    rchk(8'hde, 8'h80);
    u_host.wr(8'hde, 8'h00);
  endtask : s_soft

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end

  initial begin
    do_reset();
    s_reset_values();
    s_events();
    s_sign();
    s_summary();
    s_peak();
    s_soft();
    u_host.wr(8'hd9, 8'h3f);
    pulse(16'h0100);
    do_reset();
    s_reset_values();
    end_sim();
  end
endmodule : tb_top
